// >>> hdl/aio_pkg.sv
// constants and types shared by both ends of the converter link
// What this block does
// - 3-bit field picks one of eight sources
// - enabled converter restarts conversions by itself
// - every conversion lasts 140 microseconds
// - host waits 500 microseconds after source change
// - conversion end sets new-result flag at 0x07
// - reading flag clears it until next result
// - disable clears flag; enable starts fresh sample
// - result split: high bits 0x03, low 0x04
// - host disables converter before reading result bytes
// - host follows fixed enable-poll-stop-read sequence
// - divider enable bit 2 of 0x16, reset 1
// - reference law bit 3 of 0x16, reset 0
// - linear law disables overcurrent detection
// - pin drive bit pulls pin low when 0
// - status bit 4 of 0x01 shows pin level
// - host releases pin and selects source 7
// - six-bit current code at 0x15, reset 0
// - standby releases current-source output
// - scale supplies by 30, logic supply by 8
package aio_pkg;
  localparam int CLK_MHZ = 125;
  localparam int CONV_TIME_US = 140;
  localparam int CONV_CYC = CONV_TIME_US * CLK_MHZ;
  localparam int SETTLE_TIME_US = 500;
  localparam int SETTLE_CYC = SETTLE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 20;

  // device register offsets
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h01;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h03;
  localparam logic [7:0] ADDR_RES_LOW = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h07;
  localparam logic [7:0] ADDR_SOURCE = 8'h10;
  localparam logic [7:0] ADDR_CODE = 8'h15;
  localparam logic [7:0] ADDR_CONV_CFG = 8'h16;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h1c;

  // field positions
  localparam int PIN_LEVEL_BIT = 4;
  localparam int FLAG_BIT = 0;
  localparam int SOURCE_LSB = 5;
  localparam int ENABLE_BIT = 0;
  localparam int DIVIDER_BIT = 2;
  localparam int LAW_BIT = 3;
  localparam int PIN_DRIVE_BIT = 2;

  // reset values
  localparam logic [2:0] SOURCE_RST = 3'h0;
  localparam logic [5:0] CODE_RST = 6'h00;
  localparam logic DIVIDER_RST = 1'b1;
  localparam logic LAW_RST = 1'b0;
  localparam logic PIN_DRIVE_RST = 1'b1;
  localparam logic ENABLE_RST = 1'b0;

  // source codes
  localparam logic [2:0] SRC_LOGIC_SUPPLY = 3'h0;
  localparam logic [2:0] SRC_OUTPUT_SUPPLY = 3'h1;
  localparam logic [2:0] SRC_MAIN_SUPPLY = 3'h2;
  localparam logic [2:0] SRC_MONITOR = 3'h3;
  localparam logic [2:0] SRC_CURRENT_SENSE = 3'h4;
  localparam logic [2:0] SRC_NEGATIVE_RAIL = 3'h5;
  localparam logic [2:0] SRC_POSITIVE_RAIL = 3'h6;
  localparam logic [2:0] SRC_GENERAL_PIN = 3'h7;

  // host bus register byte offsets
  localparam logic [3:0] HOFS_CTRL = 4'h0;
  localparam logic [3:0] HOFS_ACCESS = 4'h4;
  localparam logic [3:0] HOFS_STATUS = 4'h8;
  localparam logic [3:0] HOFS_RESULT = 4'hc;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_ACC_GO_BIT = 8;
  localparam int CTRL_ACC_WE_BIT = 9;
  localparam int RESULT_SCALED_LSB = 16;

  typedef enum logic [1:0] {
    AIO_DIV_NONE,
    AIO_DIV_8,
    AIO_DIV_30
  } aio_div_t;
endpackage

// >>> hdl/aio_if.sv
// serial configuration link between host and device, one byte per access
interface aio_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input ack,
    input rdata
  );
endinterface

// >>> hdl/aio_conv_timer.sv
// free-running conversion timer, restarts while run is high
module aio_conv_timer #(
  parameter int CYC = aio_pkg::CONV_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output logic at_start,
  output logic done
);
  import aio_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic done_r;
  wire logic last = (cnt_r == CNT_W'(CYC - 1));

  assign at_start = run & (cnt_r == '0);
  assign done = done_r;
  // wraps and starts the next conversion at once
  assign cnt_nxt = (!run || last) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= run & last;
    end
  end
endmodule

// >>> hdl/aio_dev.sv
// converter control and auxiliary pin logic of the driver device
module aio_dev #(
  parameter int CONV_CYCLES = aio_pkg::CONV_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  aio_if.dev link,
  input wire logic [9:0] sample_data,
  input wire logic standby,
  input wire logic overcurrent_raw,
  input wire logic gp_pin_in,
  output logic gp_pin_out,
  output logic gp_pin_oe,
  output logic [2:0] conv_source_sel,
  output logic divider_enable,
  output logic reference_law_select,
  output logic overcurrent_detect,
  output logic [5:0] current_source_code,
  output logic current_source_oe,
  output aio_pkg::aio_div_t input_divider
);
  import aio_pkg::*;

  logic [2:0] src_r;
  logic [5:0] code_r;
  logic div_r;
  logic law_r;
  logic en_r;
  logic drive_r;
  logic flag_r;
  logic flag_nxt;
  logic [9:0] res_r;
  logic [9:0] samp_r;
  logic busy_r;
  logic ack_r;
  logic [7:0] rdata_r;
  logic oc_r;
  logic cs_oe_r;
  logic gp_oe_r;
  logic gp_out_r;
  aio_div_t div_sel_r;
  aio_div_t div_sel_nxt;
  logic conv_start;
  logic conv_done;

  // link handshake: one take per request level
  wire logic take = link.req & ~busy_r;
  wire logic wr = take & link.we;
  wire logic rd = take & ~link.we;
  wire logic wr_src = wr & (link.addr == ADDR_SOURCE);
  wire logic wr_code = wr & (link.addr == ADDR_CODE);
  wire logic wr_cfg = wr & (link.addr == ADDR_CONV_CFG);
  wire logic wr_pin = wr & (link.addr == ADDR_PIN_CTRL);
  wire logic rd_flag = rd & (link.addr == ADDR_FLAG);

  // read byte selection, unmapped addresses read zero
  wire logic [7:0] rd_pin = 8'(gp_pin_in) << PIN_LEVEL_BIT;
  wire logic [7:0] rd_high = {6'h00, res_r[9:8]};
  wire logic [7:0] rd_low = res_r[7:0];
  wire logic [7:0] rd_flg = 8'(flag_r) << FLAG_BIT;
  wire logic [7:0] rd_src = 8'(src_r) << SOURCE_LSB;
  wire logic [7:0] rd_code = {2'h0, code_r};
  wire logic [7:0] rd_cfg = (8'(law_r) << LAW_BIT)
                          | (8'(div_r) << DIVIDER_BIT)
                          | (8'(en_r) << ENABLE_BIT);
  wire logic [7:0] rd_pctl = 8'(drive_r) << PIN_DRIVE_BIT;
  wire logic [7:0] rd_byte =
    (link.addr == ADDR_PIN_STATUS) ? rd_pin :
    (link.addr == ADDR_RES_HIGH) ? rd_high :
    (link.addr == ADDR_RES_LOW) ? rd_low :
    (link.addr == ADDR_FLAG) ? rd_flg :
    (link.addr == ADDR_SOURCE) ? rd_src :
    (link.addr == ADDR_CODE) ? rd_code :
    (link.addr == ADDR_CONV_CFG) ? rd_cfg :
    (link.addr == ADDR_PIN_CTRL) ? rd_pctl :
    8'h00;

  // next enable value, used for the clear-on-disable path
  wire logic en_nxt = wr_cfg ? link.wdata[ENABLE_BIT] : en_r;

  aio_conv_timer #(
    .CYC(CONV_CYCLES)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(en_r),
    .at_start(conv_start),
    .done(conv_done)
  );

  always_comb begin
    flag_nxt = flag_r;
    if (rd_flag) begin
      flag_nxt = 1'b0;
    end
    if (conv_done) begin
      flag_nxt = 1'b1;
    end
    if (!en_nxt) begin
      flag_nxt = 1'b0;
    end
  end

  always_comb begin
    case (src_r)
      SRC_LOGIC_SUPPLY: div_sel_nxt = AIO_DIV_8;
      SRC_OUTPUT_SUPPLY,
      SRC_MAIN_SUPPLY,
      SRC_NEGATIVE_RAIL,
      SRC_POSITIVE_RAIL: div_sel_nxt = AIO_DIV_30;
      SRC_MONITOR,
      SRC_CURRENT_SENSE,
      SRC_GENERAL_PIN: div_sel_nxt = AIO_DIV_NONE;
      default: div_sel_nxt = AIO_DIV_NONE;
    endcase
  end

  // link answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      busy_r <= take | (busy_r & link.req);
      ack_r <= take;
      if (take) begin
        rdata_r <= link.we ? 8'h00 : rd_byte;
      end
    end
  end

  // writable configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_r <= SOURCE_RST;
      code_r <= CODE_RST;
      div_r <= DIVIDER_RST;
      law_r <= LAW_RST;
      en_r <= ENABLE_RST;
      drive_r <= PIN_DRIVE_RST;
    end else begin
      if (wr_src) begin
        src_r <= link.wdata[SOURCE_LSB +: 3];
      end
      if (wr_code) begin
        code_r <= link.wdata[5:0];
      end
      if (wr_cfg) begin
        div_r <= link.wdata[DIVIDER_BIT];
        law_r <= link.wdata[LAW_BIT];
      end
      en_r <= en_nxt;
      if (wr_pin) begin
        drive_r <= link.wdata[PIN_DRIVE_BIT];
      end
    end
  end

  // conversion data path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_r <= 10'h000;
      res_r <= 10'h000;
      flag_r <= 1'b0;
    end else begin
      if (conv_start) begin
        samp_r <= sample_data;
      end
      if (conv_done) begin
        res_r <= samp_r;
      end
      flag_r <= flag_nxt;
    end
  end

  // pins and analogue controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_r <= 1'b0;
      cs_oe_r <= 1'b0;
      gp_oe_r <= 1'b0;
      gp_out_r <= 1'b0;
      div_sel_r <= AIO_DIV_8;
    end else begin
      oc_r <= overcurrent_raw & ~law_r;
      cs_oe_r <= ~standby;
      gp_oe_r <= ~drive_r;
      gp_out_r <= 1'b0;
      div_sel_r <= div_sel_nxt;
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rdata_r;
  assign gp_pin_out = gp_out_r;
  assign gp_pin_oe = gp_oe_r;
  assign conv_source_sel = src_r;
  assign divider_enable = div_r;
  assign reference_law_select = law_r;
  assign overcurrent_detect = oc_r;
  assign current_source_code = code_r;
  assign current_source_oe = cs_oe_r;
  assign input_divider = div_sel_r;
endmodule

// >>> hdl/aio_host.sv
// host end: runs measurement sequences over the link, AHB-Lite command slave
//
// The AHB-Lite interface to the registers was left to the implementer.
module aio_host #(
  parameter int SETTLE_CYCLES = aio_pkg::SETTLE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  aio_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import aio_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE, H_PIN, H_DIV, H_SRC, H_SETTLE, H_EN,
    H_POLL, H_STOP, H_RDH, H_RDL, H_ACC
  } aio_hstate_t;

  aio_hstate_t st_r;
  aio_hstate_t st_nxt;
  logic req_r;
  logic [2:0] src_r;
  logic [7:0] acc_addr_r;
  logic [7:0] acc_data_r;
  logic acc_we_r;
  logic [7:0] acc_rd_r;
  logic law_sh_r;
  logic [9:0] raw_r;
  logic done_r;
  logic [CNT_W-1:0] wait_r;
  logic ap_wr_r;
  logic [3:0] ap_ofs_r;
  logic [31:0] hrdata_r;
  logic we_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;

  function automatic logic [14:0] scale(input logic [2:0] s,
                                        input logic [9:0] v);
    logic [14:0] w;
    w = {5'h00, v};
    case (s)
      SRC_LOGIC_SUPPLY: scale = w << 3;
      SRC_OUTPUT_SUPPLY, SRC_MAIN_SUPPLY,
      SRC_NEGATIVE_RAIL, SRC_POSITIVE_RAIL: scale = (w << 5) - (w << 1);
      default: scale = w;
    endcase
  endfunction

  // AHB-Lite decode, zero wait states
  wire logic ap_take = hsel & htrans[1] & hready;
  wire logic dp_wr = ap_wr_r;
  wire logic wr_ctrl = dp_wr & (ap_ofs_r == HOFS_CTRL);
  wire logic wr_acc = dp_wr & (ap_ofs_r == HOFS_ACCESS);
  wire logic idle = (st_r == H_IDLE);
  wire logic go_meas = wr_ctrl & hwdata[CTRL_GO_BIT] & idle;
  wire logic go_acc = wr_ctrl & hwdata[CTRL_ACC_GO_BIT] & idle & ~go_meas;
  wire logic [14:0] scaled = scale(src_r, raw_r);
  wire logic [31:0] rd_status = {16'h0000, acc_rd_r, 6'h00, done_r, ~idle};
  wire logic [31:0] rd_result =
    {1'b0, scaled, 6'h00, raw_r} & 32'h7fff03ff;
  wire logic [31:0] rd_word =
    (haddr[3:0] == HOFS_CTRL) ? {29'h0, src_r} << CTRL_SRC_LSB :
    (haddr[3:0] == HOFS_ACCESS) ? {16'h0000, acc_data_r, acc_addr_r} :
    (haddr[3:0] == HOFS_STATUS) ? rd_status :
    (haddr[3:0] == HOFS_RESULT) ? rd_result :
    32'h0000_0000;
  wire logic in_range = (haddr[31:4] == 28'h0000000);

  // link operation of each state
  wire logic link_state = ~idle & (st_r != H_SETTLE);
  wire logic [7:0] cfg_byte = 8'(law_sh_r) << LAW_BIT
                            | 8'(1'b1) << DIVIDER_BIT;
  wire logic op_we = (st_r != H_POLL) & (st_r != H_RDH)
                   & (st_r != H_RDL) & ((st_r != H_ACC) | acc_we_r);
  wire logic [7:0] op_addr =
    (st_r == H_PIN) ? ADDR_PIN_CTRL :
    (st_r == H_SRC) ? ADDR_SOURCE :
    (st_r == H_POLL) ? ADDR_FLAG :
    (st_r == H_RDH) ? ADDR_RES_HIGH :
    (st_r == H_RDL) ? ADDR_RES_LOW :
    (st_r == H_ACC) ? acc_addr_r :
    ADDR_CONV_CFG;
  wire logic [7:0] op_data =
    (st_r == H_PIN) ? 8'(1'b1) << PIN_DRIVE_BIT :
    (st_r == H_SRC) ? 8'(src_r) << SOURCE_LSB :
    (st_r == H_EN) ? cfg_byte | 8'(1'b1) << ENABLE_BIT :
    (st_r == H_ACC) ? acc_data_r :
    cfg_byte;
  wire logic acked = req_r & link.ack;
  wire logic settled = (wait_r == CNT_W'(SETTLE_CYCLES - 1));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      H_IDLE: begin
        if (go_meas) begin
          st_nxt = (hwdata[CTRL_SRC_LSB +: 3] == SRC_GENERAL_PIN) ?
                   H_PIN : H_DIV;
        end else if (go_acc) begin
          st_nxt = H_ACC;
        end
      end
      H_PIN: st_nxt = acked ? H_DIV : st_r;
      H_DIV: st_nxt = acked ? H_SRC : st_r;
      H_SRC: st_nxt = acked ? H_SETTLE : st_r;
      H_SETTLE: st_nxt = settled ? H_EN : st_r;
      H_EN: st_nxt = acked ? H_POLL : st_r;
      H_POLL: st_nxt = (acked & link.rdata[FLAG_BIT]) ? H_STOP : st_r;
      H_STOP: st_nxt = acked ? H_RDH : st_r;
      H_RDH: st_nxt = acked ? H_RDL : st_r;
      H_RDL: st_nxt = acked ? H_IDLE : st_r;
      H_ACC: st_nxt = acked ? H_IDLE : st_r;
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= H_IDLE;
      req_r <= 1'b0;
      wait_r <= '0;
      done_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      // link fields are registered on the same edge as req rises in a new state
      we_r <= op_we;
      addr_r <= op_addr;
      wdata_r <= op_data;
      // one byte access per request level
      req_r <= link_state & ~acked & (req_r | ~link.ack);
      wait_r <= (st_r == H_SETTLE) ? wait_r + 1'b1 : '0;
      if (go_meas | go_acc) begin
        done_r <= 1'b0;
      end else if (acked & ((st_r == H_RDL) | (st_r == H_ACC))) begin
        done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_r <= SOURCE_RST;
      acc_addr_r <= 8'h00;
      acc_data_r <= 8'h00;
      acc_we_r <= 1'b0;
      acc_rd_r <= 8'h00;
      law_sh_r <= LAW_RST;
      raw_r <= 10'h000;
    end else begin
      if (go_meas) begin
        src_r <= hwdata[CTRL_SRC_LSB +: 3];
      end
      if (go_acc) begin
        acc_we_r <= hwdata[CTRL_ACC_WE_BIT];
      end
      if (wr_acc) begin
        acc_addr_r <= hwdata[7:0];
        acc_data_r <= hwdata[15:8];
      end
      if (acked & (st_r == H_ACC)) begin
        acc_rd_r <= link.rdata;
        if (acc_we_r & (acc_addr_r == ADDR_CONV_CFG)) begin
          law_sh_r <= acc_data_r[LAW_BIT];
        end
      end
      if (acked & (st_r == H_RDH)) begin
        raw_r[9:8] <= link.rdata[1:0];
      end
      if (acked & (st_r == H_RDL)) begin
        raw_r[7:0] <= link.rdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_ofs_r <= 4'h0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      ap_wr_r <= ap_take & hwrite & in_range;
      ap_ofs_r <= haddr[3:0];
      if (ap_take & ~hwrite) begin
        hrdata_r <= in_range ? rd_word : 32'h0000_0000;
      end
    end
  end

  assign link.req = req_r;
  assign link.we = we_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
endmodule

// >>> sim/aio_checker.sv
// concurrent checks on the converter link and the device pins
module aio_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic ack,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic standby,
  input wire logic overcurrent_raw,
  input wire logic reference_law_select,
  input wire logic overcurrent_detect,
  input wire logic current_source_oe,
  input wire logic gp_pin_out,
  input wire logic gp_pin_oe,
  input wire logic [2:0] conv_source_sel,
  input wire aio_pkg::aio_div_t input_divider
);
  import aio_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // divider expected for a source code
  function automatic aio_div_t div_of(input logic [2:0] s);
    if (s == SRC_LOGIC_SUPPLY) return AIO_DIV_8;
    if (s inside {3'h1, 3'h2, 3'h5, 3'h6}) return AIO_DIV_30;
    return AIO_DIV_NONE;
  endfunction

  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack wider than one cycle");

  property p_req_answer;
    $rose(req) |=> ack;
  endproperty
  a_req_answer: assert property (p_req_answer)
    else $error("no ack one cycle after request");

  property p_req_hold;
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before ack");

  property p_req_drop;
    ack |=> !req;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("request held after ack");

  property p_ovc_linear;
    reference_law_select |=> !overcurrent_detect;
  endproperty
  a_ovc_linear: assert property (p_ovc_linear)
    else $error("overcurrent active in linear mode");

  property p_ovc_log;
    !reference_law_select && overcurrent_raw |=> overcurrent_detect;
  endproperty
  a_ovc_log: assert property (p_ovc_log)
    else $error("overcurrent missed in log mode");

  property p_standby;
    hresetn |=> current_source_oe != $past(standby);
  endproperty
  a_standby: assert property (p_standby)
    else $error("current source enable wrong for standby");

  property p_open_coll;
    gp_pin_oe |-> !gp_pin_out;
  endproperty
  a_open_coll: assert property (p_open_coll)
    else $error("general pin driven high");

  property p_divider;
    1'b1 |=> input_divider == div_of($past(conv_source_sel));
  endproperty
  a_divider: assert property (p_divider)
    else $error("input divider wrong for source");
endmodule

// >>> sim/test_adc_sequencer_aux_io.sv
// bench: host end driven over the bus, device pins driven and watched
module test_adc_sequencer_aux_io;
  timeunit 1ns;
  timeprecision 1ps;
  import aio_pkg::*;
  localparam int CONV = 60;
  localparam int SETTLE = 10;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [9:0] sample_data = 10'h000;
  logic standby = 1'b0;
  logic overcurrent_raw = 1'b0;
  logic ext_level = 1'b1;
  logic hreadyout, hresp, gp_pin_in, gp_pin_out, gp_pin_oe;
  logic divider_enable, reference_law_select, overcurrent_detect;
  logic current_source_oe;
  logic [31:0] hrdata, rd;
  logic [2:0] conv_source_sel;
  logic [5:0] current_source_code;
  logic [7:0] q;
  aio_div_t input_divider;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int t0, n;
  aio_if aio_if_inst ();
  // external pull-up unless the device pulls the pin low
  assign gp_pin_in = gp_pin_oe ? gp_pin_out : ext_level;
  always #4 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  int src_cyc = 0;
  int gap = 0;
  // cycles from the source write to the next enabling write
  always @(posedge hclk) begin
    if (aio_if_inst.req && aio_if_inst.ack && aio_if_inst.we) begin
      if (aio_if_inst.addr == ADDR_SOURCE) begin
        src_cyc <= cyc;
      end
      if (aio_if_inst.addr == ADDR_CONV_CFG &&
          aio_if_inst.wdata[ENABLE_BIT]) begin
        gap <= cyc - src_cyc;
      end
    end
  end

  aio_dev #(.CONV_CYCLES(CONV)) aio_dev_inst (
    .hclk, .hresetn, .link(aio_if_inst.dev), .sample_data, .standby,
    .overcurrent_raw, .gp_pin_in, .gp_pin_out, .gp_pin_oe,
    .conv_source_sel, .divider_enable, .reference_law_select,
    .overcurrent_detect, .current_source_code, .current_source_oe,
    .input_divider
  );
  aio_host #(.SETTLE_CYCLES(SETTLE)) aio_host_inst (
    .hclk, .hresetn, .link(aio_if_inst.host), .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata
  );
  aio_checker aio_checker_inst (
    .hclk, .hresetn, .req(aio_if_inst.req), .ack(aio_if_inst.ack),
    .we(aio_if_inst.we), .addr(aio_if_inst.addr),
    .wdata(aio_if_inst.wdata), .standby, .overcurrent_raw,
    .reference_law_select, .overcurrent_detect, .current_source_oe,
    .gp_pin_out, .gp_pin_oe, .conv_source_sel, .input_divider
  );

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic give_up();
    mismatches++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) give_up();
      @(posedge hclk);
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic poll_idle(output logic [31:0] s);
    int k;
    k = 0;
    do begin
      bus(1'b0, 32'h8, 32'h0, s);
      k++;
    end while (s[0] !== 1'b0 && k < 3000);
    if (s[0] !== 1'b0) give_up();
  endtask

  // single byte access to the device through the host
  task automatic dev_acc(input logic w, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] r);
    logic [31:0] s;
    bus(1'b1, 32'h4, {16'h0, d, a}, s);
    bus(1'b1, 32'h0, {22'h0, w, 1'b1, 8'h0}, s);
    poll_idle(s);
    r = s[15:8];
  endtask

  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    dev_acc(1'b1, a, d, q);
  endtask

  task automatic dr_chk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    dev_acc(1'b0, a, 8'h00, q);
    chk({24'h0, q & m}, {24'h0, e});
  endtask

  task automatic measure(input logic [2:0] src, input logic [9:0] raw);
    logic [31:0] s, sc;
    sample_data <= raw;
    bus(1'b1, 32'h0, {25'h0, src, 4'h1}, s);
    poll_idle(s);
    chk({31'h0, gap >= SETTLE}, 32'h1);
    bus(1'b0, 32'hc, 32'h0, s);
    sc = 32'(raw);
    if (src == 3'h0) sc = sc * 8;
    if (src inside {3'h1, 3'h2, 3'h5, 3'h6}) sc = sc * 30;
    chk({22'h0, s[9:0]}, {22'h0, raw});
    chk({17'h0, s[30:16]}, sc);
    chk({29'h0, conv_source_sel}, {29'h0, src});
    bus(1'b0, 32'h0, 32'h0, s);
    chk(s, {25'h0, src, 4'h0});
    sample_data <= ~raw;
    dr_chk(ADDR_SOURCE, 8'he0, {src, 5'h0});
    dr_chk(ADDR_RES_HIGH, 8'h03, {6'h0, raw[9:8]});
    dr_chk(ADDR_RES_LOW, 8'hff, raw[7:0]);
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    dr_chk(ADDR_SOURCE, 8'he0, 8'h00);
    dr_chk(ADDR_CODE, 8'h3f, 8'h00);
    dr_chk(ADDR_CONV_CFG, 8'h0d, 8'h04);
    dr_chk(ADDR_PIN_CTRL, 8'h04, 8'h04);
    dr_chk(ADDR_FLAG, 8'h01, 8'h00);
    bus(1'b0, 32'h40, 32'h0, rd);
    chk(rd, 32'h0);
    dw(ADDR_CODE, 8'h3f);
    chk({26'h0, current_source_code}, 32'h3f);
    dr_chk(ADDR_CODE, 8'h3f, 8'h3f);
    standby <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({31'h0, current_source_oe}, 32'h0);
    standby <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({31'h0, current_source_oe}, 32'h1);
    dw(ADDR_CONV_CFG, 8'h00);
    chk({31'h0, divider_enable}, 32'h0);
    overcurrent_raw <= 1'b1;
    dw(ADDR_CONV_CFG, 8'h0c);
    chk({30'h0, reference_law_select, overcurrent_detect}, 32'h2);
    dw(ADDR_CONV_CFG, 8'h04);
    chk({31'h0, overcurrent_detect}, 32'h1);
    overcurrent_raw <= 1'b0;
    dw(ADDR_PIN_CTRL, 8'h00);
    chk({31'h0, gp_pin_oe}, 32'h1);
    dr_chk(ADDR_PIN_STATUS, 8'h10, 8'h00);
    dw(ADDR_PIN_CTRL, 8'h04);
    dr_chk(ADDR_PIN_STATUS, 8'h10, 8'h10);
    ext_level <= 1'b0;
    dr_chk(ADDR_PIN_STATUS, 8'h10, 8'h00);
    ext_level <= 1'b1;
    dw(ADDR_PIN_CTRL, 8'h00);
    for (int i = 0; i < 8; i++) begin
      measure(3'(i), 10'h3ff - 10'(i * 37));
    end
    chk({31'h0, gp_pin_oe}, 32'h0);
    // fresh sample at enable, later samples replace it
    sample_data <= 10'h155;
    t0 = cyc;
    dw(ADDR_CONV_CFG, 8'h05);
    sample_data <= 10'h2aa;
    n = 0;
    do begin
      dev_acc(1'b0, ADDR_FLAG, 8'h00, q);
      n++;
    end while (q[0] !== 1'b1 && n < 200);
    chk({31'h0, q[0]}, 32'h1);
    chk({31'h0, cyc - t0 >= CONV && cyc - t0 <= CONV + 40}, 32'h1);
    dr_chk(ADDR_FLAG, 8'h01, 8'h00);
    dr_chk(ADDR_RES_LOW, 8'hff, 8'h55);
    repeat (CONV) @(posedge hclk);
    dr_chk(ADDR_FLAG, 8'h01, 8'h01);
    repeat (CONV) @(posedge hclk);
    dw(ADDR_CONV_CFG, 8'h04);
    dr_chk(ADDR_FLAG, 8'h01, 8'h00);
    dr_chk(ADDR_RES_HIGH, 8'h03, 8'h02);
    dr_chk(ADDR_RES_LOW, 8'hff, 8'haa);
    repeat (CONV + 10) @(posedge hclk);
    dr_chk(ADDR_FLAG, 8'h01, 8'h00);
    wrap_up();
  end
endmodule
